// ===== verilog/pmcc_top.sv
`timescale 1ns/10ps
`default_nettype none

module pmcc_top #(
    parameter int NPERIPH = 8,
    parameter int NWAKE   = 4
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire pmcc_pkg::pmcc_apb_req_t apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [NWAKE-1:0]      wake_pin_in,
    input  wire logic                  dma_l1_req,
    output logic                       dma_l1_grant,
    output pmcc_pkg::pmcc_ctl_t        pm_ctl,
    output logic [NPERIPH-1:0]         periph_clk_en,
    output logic                       regulator_wake_out,
    output logic [3:0]                 core_vdd_level
);

    typedef struct packed {
        pmcc_pkg::pmcc_mode_t mode;
        logic                 act_pll;
        logic                 vr_on;
        logic [3:0]           vr_lvl;
        logic [NPERIPH-1:0]   pgate;
        logic [NWAKE-1:0]     wake_en;
        logic [NWAKE-1:0]     wsync1;
        logic [NWAKE-1:0]     wsync2;
        logic [3:0]           wcnt;
        pmcc_pkg::pmcc_ctl_t  ctl;
        logic [NPERIPH-1:0]   pclk;
        logic                 rwake;
        logic [31:0]          rdata;
        logic                 err;
    } pmcc_state_t;

    pmcc_state_t st_ff;
    pmcc_state_t nxt_st;

    function automatic pmcc_pkg::pmcc_ctl_t mode_ctl(input pmcc_pkg::pmcc_mode_t m,
                                                     input logic act_pll);
        pmcc_pkg::pmcc_ctl_t c;
        c = '0;
        unique case (m)
            pmcc_pkg::PMCC_FULL:   c = 5'b10111;
            pmcc_pkg::PMCC_ACTIVE: c = {act_pll, 4'b1111};
            pmcc_pkg::PMCC_SLEEP:  c = 5'b10011;
            pmcc_pkg::PMCC_DEEP:   c = 5'b00001;
            pmcc_pkg::PMCC_HIBER:  c = 5'b00000;
            default:               c = 5'b00000;
        endcase
        return c;
    endfunction

    function automatic logic [2:0] mode_code(input pmcc_pkg::pmcc_mode_t m);
        logic [2:0] k;
        k = pmcc_pkg::CODE_FULL;
        unique case (m)
            pmcc_pkg::PMCC_FULL:   k = pmcc_pkg::CODE_FULL;
            pmcc_pkg::PMCC_ACTIVE: k = pmcc_pkg::CODE_ACTIVE;
            pmcc_pkg::PMCC_SLEEP:  k = pmcc_pkg::CODE_SLEEP;
            pmcc_pkg::PMCC_DEEP:   k = pmcc_pkg::CODE_DEEP;
            pmcc_pkg::PMCC_HIBER:  k = pmcc_pkg::CODE_HIBER;
            default:               k = pmcc_pkg::CODE_FULL;
        endcase
        return k;
    endfunction

    logic        setup;
    logic        wr;
    logic        mapped;
    logic        wake_ok;
    logic [31:0] rd_mux;

    always_comb begin
        setup  = apb_req.psel && !apb_req.penable;
        wr     = apb_req.psel && apb_req.penable && apb_req.pwrite;
        mapped = (apb_req.paddr == pmcc_pkg::MODE_OFS) ||
                 (apb_req.paddr == pmcc_pkg::VRCTL_OFS) ||
                 (apb_req.paddr == pmcc_pkg::PGATE_OFS) ||
                 (apb_req.paddr == pmcc_pkg::STAT_OFS) ||
                 (apb_req.paddr == pmcc_pkg::WAKE_OFS);
        wake_ok = st_ff.wcnt >= 4'(pmcc_pkg::WAKE_CYC);
        rd_mux = '0;
        unique case (apb_req.paddr)
            pmcc_pkg::MODE_OFS:  rd_mux = {28'h0000000, st_ff.act_pll, mode_code(st_ff.mode)};
            pmcc_pkg::VRCTL_OFS: rd_mux = {24'h000000, st_ff.vr_lvl, 3'h0, st_ff.vr_on};
            pmcc_pkg::PGATE_OFS: rd_mux = 32'(st_ff.pgate);
            pmcc_pkg::STAT_OFS:  rd_mux = {21'h000000, st_ff.rwake, st_ff.ctl, st_ff.mode};
            pmcc_pkg::WAKE_OFS:  rd_mux = 32'(st_ff.wake_en);
            default:             rd_mux = '0;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        // The first stage feeds only the second; wake logic reads the second.
        nxt_st.wsync1 = wake_pin_in;
        nxt_st.wsync2 = st_ff.wsync1;
        if ((st_ff.wsync2 & st_ff.wake_en) != '0) begin
            if (!wake_ok) begin
                nxt_st.wcnt = st_ff.wcnt + 4'h1;
            end
        end else begin
            nxt_st.wcnt = '0;
        end

        if (setup) begin
            nxt_st.rdata = rd_mux;
            nxt_st.err   = !mapped;
        end

        if (wr && mapped) begin
            unique case (apb_req.paddr)
                pmcc_pkg::MODE_OFS: begin
                    nxt_st.act_pll = apb_req.pwdata[pmcc_pkg::MODE_ACT_PLL_BIT];
                    // Illegal codes and hibernate requests leave the mode alone
                    // Deep sleep ignores mode writes, so only reset, wake or a regulator write that forces hibernate ends it.
                    if (st_ff.mode != pmcc_pkg::PMCC_DEEP) begin
                        unique case (apb_req.pwdata[2:0])
                            pmcc_pkg::CODE_FULL:   nxt_st.mode = pmcc_pkg::PMCC_FULL;
                            pmcc_pkg::CODE_ACTIVE: nxt_st.mode = pmcc_pkg::PMCC_ACTIVE;
                            pmcc_pkg::CODE_SLEEP:  nxt_st.mode = pmcc_pkg::PMCC_SLEEP;
                            pmcc_pkg::CODE_DEEP:   nxt_st.mode = pmcc_pkg::PMCC_DEEP;
                            default:               nxt_st.mode = st_ff.mode;
                        endcase
                    end
                end
                pmcc_pkg::VRCTL_OFS: begin
                    nxt_st.vr_on  = apb_req.pwdata[pmcc_pkg::VR_ON_BIT];
                    nxt_st.vr_lvl = apb_req.pwdata[pmcc_pkg::VR_LVL_LSB +: 4];
                end
                pmcc_pkg::PGATE_OFS: nxt_st.pgate = apb_req.pwdata[NPERIPH-1:0];
                pmcc_pkg::WAKE_OFS:  nxt_st.wake_en = apb_req.pwdata[NWAKE-1:0];
                default:             nxt_st.err = st_ff.err;
            endcase
        end

        // Sleep and deep sleep leave on a held wake level; hibernate needs the regulator back on and a mode write.
        if (wake_ok && (st_ff.mode == pmcc_pkg::PMCC_SLEEP ||
                        st_ff.mode == pmcc_pkg::PMCC_DEEP)) begin
            nxt_st.mode = pmcc_pkg::PMCC_FULL;
        end

        if (!nxt_st.vr_on || nxt_st.vr_lvl == pmcc_pkg::VR_LVL_OFF) begin
            nxt_st.mode = pmcc_pkg::PMCC_HIBER;
        end

        // Enables are registered so clock gates only see clean edges.
        nxt_st.ctl   = mode_ctl(nxt_st.mode, nxt_st.act_pll);
        nxt_st.pclk  = nxt_st.ctl.sys_clk_en ? nxt_st.pgate : '0;
        nxt_st.rwake = nxt_st.vr_on && nxt_st.mode != pmcc_pkg::PMCC_HIBER;
    end

    // Only the external reset reloads the regulator fields (on, level 0xC), so they survive
    // hibernate while the I/O supply holds this flop bank.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_ff.mode    <= pmcc_pkg::PMCC_FULL;
            st_ff.act_pll <= 1'b1;
            st_ff.vr_on   <= 1'b1;
            st_ff.vr_lvl  <= pmcc_pkg::VR_LVL_RST;
            st_ff.pgate   <= '1;
            st_ff.wake_en <= '0;
            st_ff.wsync1  <= '0;
            st_ff.wsync2  <= '0;
            st_ff.wcnt    <= '0;
            st_ff.ctl     <= 5'b10111;
            st_ff.pclk    <= '1;
            st_ff.rwake   <= 1'b1;
            st_ff.rdata   <= '0;
            st_ff.err     <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        prdata             = st_ff.rdata;
        pready             = 1'b1;
        pslverr            = apb_req.psel && apb_req.penable && st_ff.err;
        pm_ctl             = st_ff.ctl;
        periph_clk_en      = st_ff.pclk;
        regulator_wake_out = st_ff.rwake;
        core_vdd_level     = st_ff.vr_lvl;
        dma_l1_grant       = dma_l1_req && st_ff.mode != pmcc_pkg::PMCC_SLEEP &&
                             st_ff.ctl.sys_clk_en;
    end

endmodule

`default_nettype wire

// ===== verilog/pmcc_pkg.sv
// Function
// - Full-on: PLL on, unbypassed, all clocks, power.
// - Reset leaves the block in full-on mode.
// - Active: PLL bypassed, clocks and power on.
// - Sleep: PLL and system clock on, core off.
// - Deep sleep: PLL, core, system clocks off.
// - Hibernate: everything off, core power off.
// - Zero core voltage setting enters hibernate.
// - Each peripheral clock gated individually.
// - Core voltage level changeable by software.
// - Deep sleep exits only on reset, wake or a regulator write that forces hibernate.
// - Supply-off bit zero drives regulator wake low.
// - Regulator register kept through hibernate.
// - No system DMA to L1 in sleep.
package pmcc_pkg;

    localparam int CLK_NS       = 4;
    localparam int WAKE_HOLD_NS = 10;
    // A shortest time rounds down: two samples fit in every held level.
    localparam int WAKE_CYC     = (WAKE_HOLD_NS / CLK_NS < 1) ? 1 : WAKE_HOLD_NS / CLK_NS;

    localparam logic [11:0] MODE_OFS  = 12'h000;
    localparam logic [11:0] VRCTL_OFS = 12'h004;
    localparam logic [11:0] PGATE_OFS = 12'h008;
    localparam logic [11:0] STAT_OFS  = 12'h00C;
    localparam logic [11:0] WAKE_OFS  = 12'h010;

    localparam logic [2:0] CODE_FULL   = 3'h0;
    localparam logic [2:0] CODE_ACTIVE = 3'h1;
    localparam logic [2:0] CODE_SLEEP  = 3'h2;
    localparam logic [2:0] CODE_DEEP   = 3'h3;
    localparam logic [2:0] CODE_HIBER  = 3'h4;

    localparam int MODE_ACT_PLL_BIT = 3;
    localparam int VR_ON_BIT        = 0;
    localparam int VR_LVL_LSB       = 4;
    localparam logic [3:0] VR_LVL_RST = 4'hC;
    localparam logic [3:0] VR_LVL_OFF = 4'h0;

    typedef enum logic [4:0] {
        PMCC_FULL   = 5'b00001,
        PMCC_ACTIVE = 5'b00010,
        PMCC_SLEEP  = 5'b00100,
        PMCC_DEEP   = 5'b01000,
        PMCC_HIBER  = 5'b10000
    } pmcc_mode_t;

    typedef struct packed {
        logic pll_en;
        logic pll_bypass;
        logic core_clk_en;
        logic sys_clk_en;
        logic core_pwr;
    } pmcc_ctl_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pmcc_apb_req_t;

endpackage

// ===== dv/pmcc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pmcc_partner (
    input  wire logic  clk,
    input  wire logic  fire,
    input  wire logic  regulator_wake_out,
    output logic [3:0] wake_pin_in,
    output logic       supply_ok
);
    logic [1:0] hold_ff = 2'h0;
    // Three cycles of 4 ns hold the wake level past the 10 ns minimum.
    always_ff @(posedge clk) begin
        hold_ff   <= fire ? 2'h3 : hold_ff - 2'(hold_ff != 2'h0);
        supply_ok <= regulator_wake_out;
    end
    assign wake_pin_in = {3'h0, hold_ff != 2'h0};
endmodule
`default_nettype wire

// ===== dv/pmcc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pmcc_checker #(
    parameter int NPERIPH = 8,
    parameter int NWAKE   = 4
) (
    input wire logic                    clk,
    input wire logic                    resetn,
    input wire pmcc_pkg::pmcc_apb_req_t apb_req,
    input wire logic [NWAKE-1:0]        wake_pin_in,
    input wire logic                    dma_l1_req,
    input wire logic                    dma_l1_grant,
    input wire pmcc_pkg::pmcc_ctl_t     pm_ctl,
    input wire logic [NPERIPH-1:0]      periph_clk_en,
    input wire logic                    regulator_wake_out,
    input wire logic [3:0]              core_vdd_level
);
    logic [2:0] quiet_ff;
    logic [2:0] nxt_quiet;
    // Wake pins pass two sync flops, so a quiet span of seven cycles is needed.
    always_comb begin
        nxt_quiet = (apb_req.psel || |wake_pin_in) ? 3'h0 : quiet_ff + 3'(quiet_ff != 3'h7);
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quiet_ff <= 3'h0;
        end else begin
            quiet_ff <= nxt_quiet;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_full_after_rst: assert property ($rose(resetn) |-> pm_ctl == 5'h17)
        else $error("not full-on after reset");
    a_unbyp_pll_on: assert property (pm_ctl.core_clk_en && !pm_ctl.pll_bypass |-> pm_ctl.pll_en)
        else $error("core runs unbypassed without pll");
    a_core_needs_sys: assert property (pm_ctl.core_clk_en |-> pm_ctl.sys_clk_en && pm_ctl.core_pwr)
        else $error("core clock without system clock");
    a_sys_off_all: assert property (!pm_ctl.sys_clk_en |-> !pm_ctl.pll_en && !pm_ctl.core_clk_en)
        else $error("deep state leaves pll or core on");
    a_pwr_follows: assert property (regulator_wake_out == pm_ctl.core_pwr)
        else $error("regulator wake differs from core power");
    a_vdd_zero_hib: assert property (core_vdd_level == 4'h0 |-> ##[0:1] !regulator_wake_out)
        else $error("zero level did not hibernate");
    a_periph_gated: assert property (!pm_ctl.sys_clk_en |-> periph_clk_en == '0)
        else $error("peripheral clock on without system clock");
    a_dma_grant: assert property (dma_l1_grant == (dma_l1_req && pm_ctl.core_clk_en))
        else $error("dma grant wrong for mode");
    a_quiet_stable: assert property (quiet_ff == 3'h7 && !apb_req.psel && !(|wake_pin_in)
        |=> $stable(pm_ctl))
        else $error("mode changed with no cause");
endmodule
bind pmcc_top pmcc_checker #(.NPERIPH(NPERIPH), .NWAKE(NWAKE)) pmcc_checker_inst (.clk,
    .resetn, .apb_req, .wake_pin_in, .dma_l1_req, .dma_l1_grant, .pm_ctl, .periph_clk_en,
    .regulator_wake_out, .core_vdd_level);
`default_nettype wire

// ===== dv/pmcc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pmcc_top_tb;
    localparam logic [11:0] MOD = pmcc_pkg::MODE_OFS;
    localparam logic [11:0] VR  = pmcc_pkg::VRCTL_OFS;
    logic                    clk = 1'b0;
    logic                    resetn = 1'b0;
    logic                    dma_l1_req = 1'b1;
    logic                    fire = 1'b0;
    pmcc_pkg::pmcc_apb_req_t req = '0;
    logic [31:0]             prdata, rd;
    logic                    pready, pslverr, err, dma_l1_grant, reg_wake, supply_ok;
    logic [3:0]              wake, vdd;
    logic [7:0]              pclk;
    pmcc_pkg::pmcc_ctl_t     pm_ctl;
    int                      n_errors = 0;
    int                      n_checks = 0;
    logic [4:0]              ms [5] = '{5'h1F, 5'h1F, 5'h17, 5'h17, 5'h17};
    logic [4:0]              ex [5] = '{5'h17, 5'h1F, 5'h13, 5'h01, 5'h00};
    logic                    gr [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    always #2 clk = ~clk;
    pmcc_top pmcc_top_inst (.clk, .resetn, .apb_req(req), .prdata, .pready, .pslverr,
        .wake_pin_in(wake), .dma_l1_req, .dma_l1_grant, .pm_ctl, .periph_clk_en(pclk),
        .regulator_wake_out(reg_wake), .core_vdd_level(vdd));
    pmcc_partner pmcc_partner_inst (.clk, .fire, .regulator_wake_out(reg_wake),
        .wake_pin_in(wake), .supply_ok);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // Outputs launched by the access edge are read once they have settled.
        @(negedge clk);
    endtask
    task automatic mode_is(input int c);
        apb(1'b0, pmcc_pkg::STAT_OFS, 32'h0);
        chk(32'(pm_ctl & ms[c]), 32'(ex[c]));
        chk(32'(rd[4:0]), 32'(5'h01 << c));
        chk(32'(dma_l1_grant), 32'(gr[c]));
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #8000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        mode_is(0);
        chk(32'({pclk, reg_wake, vdd}), 32'h1FFC);
        apb(1'b1, pmcc_pkg::PGATE_OFS, 32'hA5);
        chk(32'(pclk), 32'hA5);
        apb(1'b1, pmcc_pkg::WAKE_OFS, 32'h1);
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, MOD, 32'(c) | 32'h8);
            mode_is(c);
        end
        chk(32'(pclk), 32'h0);
        apb(1'b1, MOD, 32'h0);
        mode_is(3);
        @(posedge clk) fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        repeat (10) @(posedge clk);
        mode_is(0);
        $display("test modes done");
        apb(1'b1, VR, 32'h51);
        chk(32'(vdd), 32'h5);
        apb(1'b1, VR, 32'h01);
        mode_is(4);
        chk(32'({reg_wake, supply_ok}), 32'h0);
        apb(1'b0, VR, 32'h0);
        chk(rd, 32'h01);
        apb(1'b1, VR, 32'hC1);
        apb(1'b1, MOD, 32'h0);
        mode_is(0);
        apb(1'b1, VR, 32'hC0);
        chk(32'(reg_wake), 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        $display("test regulator done");
        summarize();
    end
endmodule
`default_nettype wire
